// ===== rtl/sram_host.sv
// host controller for an asynchronous 16-bit static ram
// assumes a 200 MHz clock; one request at a time over a valid/ready handshake
//
// Summary of operation
// RL1 - write spans strobe, selects and byte enables
// RL2 - setup measured from write-ending strobe edge
// RL3 - data stable a setup time before end
// RL4 - data held through the ending edge
// RL5 - address valid a setup time before end
// RL6 - address held stable past write end
// RL7 - byte enables held a setup before end
// RL8 - read data sampled after address access
// RL9 - old data held briefly after address
// RL10 - output-enable access time before sampling
// RL11 - data floats shortly after output disable
// RL12 - byte lane valid after byte enable
// RL13 - byte lane floats after byte disable
// RL14 - device floats data during write
// RL15 - deselect with strobe high stays floating
// RL16 - host never drives while device drives
// RL17 - write strobe high throughout reads
// RL18 - address valid before read enables assert; the host switches address and read enables on the same clock edge
// RL19 - each cycle lasts the minimum cycle
// RL20 - one speed-grade input picks all figures
// RL21 - lower enable lane 0-7, upper 8-15
// RL22 - deselected means device floats data
// RL23 - read needs select, output enable, strobe high
module sram_host
    import sram_host_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic slow_grade,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [addr_width-1:0] req_addr,
    input wire logic [data_width-1:0] req_wdata,
    input wire logic [1:0] req_byte_en,
    output logic rsp_valid,
    output logic [data_width-1:0] rsp_rdata,
    output logic [addr_width-1:0] sram_addr,
    output logic chip_select_n,
    output logic chip_select_hi,
    output logic write_n,
    output logic output_en_n,
    output logic upper_byte_sel_n,
    output logic lower_byte_sel_n,
    output logic [data_width-1:0] sram_data_out,
    output logic sram_data_oe,
    input wire logic [data_width-1:0] sram_data_in
);
    import sram_host_pkg::*;

    // cycle counts per grade; three more read cycles cover pin stage and input sync
    localparam int sync_lag = 3;
    localparam logic [4:0] wr_len [2] = '{
        5'(ns_to_cyc_up(cycle_min_ns[0])), 5'(ns_to_cyc_up(cycle_min_ns[1]))};
    localparam logic [4:0] rd_len [2] = '{
        5'(ns_to_cyc_up(access_max_ns[0]) + sync_lag),
        5'(ns_to_cyc_up(access_max_ns[1]) + sync_lag)};
    localparam logic [4:0] float_len [2] = '{
        5'(ns_to_cyc_up(float_max_ns[0])), 5'(ns_to_cyc_up(float_max_ns[1]))};

    sram_pins_if pif ();

    host_state_t state_q, state_d;
    logic [4:0] cnt_q, cnt_d;
    logic grade_q, grade_d;
    logic wr_q, wr_d;
    logic [addr_width-1:0] addr_q, addr_d;
    logic [data_width-1:0] wdata_q, wdata_d;
    logic [1:0] be_q, be_d;
    logic rsp_valid_q, rsp_valid_d;
    logic [data_width-1:0] rdata_q, rdata_d;

    // mask off lanes the request did not enable
    function automatic logic [data_width-1:0] lane_mask(input logic [1:0] be,
            input logic [data_width-1:0] d);
        // RL21 lane to enable
        return {be[1] ? d[15:8] : 8'h00, be[0] ? d[7:0] : 8'h00};
    endfunction

    // RL20 grade picks figures
    assign req_ready = (state_q == st_idle);

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        grade_d = grade_q;
        wr_d = wr_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        be_d = be_q;
        rsp_valid_d = 1'b0;
        rdata_d = rdata_q;
        case (state_q)
            st_idle: begin
                grade_d = slow_grade;
                if (req_valid && req_byte_en != 2'h0) begin
                    // RL18 address latched with selects
                    addr_d = req_addr;
                    wdata_d = req_wdata;
                    be_d = req_byte_en;
                    wr_d = req_write;
                    cnt_d = 5'h00;
                    state_d = req_write ? st_write : st_read;
                end else if (req_valid) begin
                    rsp_valid_d = 1'b1;
                end
            end
            st_write: begin
                // RL19 full cycle length
                if (cnt_q == wr_len[grade_q] - 5'h01) begin
                    cnt_d = 5'h00;
                    rsp_valid_d = 1'b1;
                    state_d = st_float;
                end else begin
                    cnt_d = cnt_q + 5'h01;
                end
            end
            st_read: begin
                // RL8 wait full access
                if (cnt_q == rd_len[grade_q] - 5'h01) begin
                    // RL12 masked lanes
                    rdata_d = lane_mask(be_q, pif.rdata);
                    rsp_valid_d = 1'b1;
                    cnt_d = 5'h00;
                    state_d = st_float;
                end else begin
                    cnt_d = cnt_q + 5'h01;
                end
            end
            st_float: begin
                // RL11 float gap
                if (cnt_q == float_len[grade_q] - 5'h01) begin
                    cnt_d = 5'h00;
                    state_d = st_idle;
                end else begin
                    cnt_d = cnt_q + 5'h01;
                end
            end
            default: begin
                state_d = st_idle;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= st_idle;
            cnt_q <= 5'h00;
            grade_q <= grade_reset;
            wr_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= '0;
            be_q <= 2'h0;
            rsp_valid_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            grade_q <= grade_d;
            wr_q <= wr_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            be_q <= be_d;
            rsp_valid_q <= rsp_valid_d;
            rdata_q <= rdata_d;
        end
    end

    assign rsp_valid = rsp_valid_q;
    assign rsp_rdata = rdata_q;

    // pin levels from the current state
    logic in_wr, strobe_on, in_rd;
    assign in_wr = (state_q == st_write);
    assign in_rd = (state_q == st_read);
    // RL1 strobe inside select window
    // RL2 strobe edge ends write
    assign strobe_on = in_wr && cnt_q != 5'h00 && cnt_q != wr_len[grade_q] - 5'h01;

    // RL5 address setup kept
    // RL6 address held past end
    assign pif.addr = addr_q;
    // RL22 deselect outside cycles
    assign pif.chip_select_n = !(in_wr || in_rd);
    assign pif.chip_select_hi = in_wr || in_rd;
    // RL17 strobe high on reads
    assign pif.write_n = !strobe_on;
    // RL23 read with output enable
    // RL14 output enable off on writes
    assign pif.output_en_n = !in_rd;
    // RL7 byte enables span cycle
    assign pif.upper_byte_sel_n = !((in_wr || in_rd) && be_q[1]);
    assign pif.lower_byte_sel_n = !((in_wr || in_rd) && be_q[0]);
    // RL3 data steady before end
    // RL4 data held at end
    assign pif.wdata = wdata_q;
    // RL16 drive only during write
    assign pif.data_oe = in_wr;

    sram_pin_stage u_stage (
        .clock(clock),
        .rst(rst),
        .p(pif.pins),
        .sram_addr(sram_addr),
        .chip_select_n(chip_select_n),
        .chip_select_hi(chip_select_hi),
        .write_n(write_n),
        .output_en_n(output_en_n),
        .upper_byte_sel_n(upper_byte_sel_n),
        .lower_byte_sel_n(lower_byte_sel_n),
        .sram_data_out(sram_data_out),
        .sram_data_oe(sram_data_oe),
        .sram_data_in(sram_data_in)
    );
endmodule // sram_host

// ===== rtl/sram_host_pkg.sv
// timing constants, speed-grade figures and host state encoding for the sram host
// assumes a 200 MHz clock; figures are in ns; sram_host converts only the cycle, access and float ones to cycles
package sram_host_pkg;
    localparam int clk_period_ns = 5;
    localparam int addr_width = 20;
    localparam int data_width = 16;

    // speed-grade figures, index 0 fast, 1 slow
    localparam int cycle_min_ns [2] = '{55, 70};
    localparam int addr_setup_ns [2] = '{40, 60};
    localparam int data_setup_ns [2] = '{25, 30};
    localparam int byte_setup_ns [2] = '{40, 60};
    localparam int access_max_ns [2] = '{55, 70};
    localparam int oe_access_ns [2] = '{25, 35};
    localparam int float_max_ns [2] = '{20, 25};

    // least times round up to whole cycles
    function automatic int ns_to_cyc_up(input int ns);
        int c;
        c = (ns + clk_period_ns - 1) / clk_period_ns;
        return (c < 1) ? 1 : c;
    endfunction

    localparam logic [0:0] grade_reset = 1'h0;

    typedef enum logic [2:0] {
        st_idle,
        st_write,
        st_read,
        st_float
    } host_state_t;
endpackage

// ===== rtl/sram_pins_if.sv
// pin-level carrier between the host sequencer and its pin register stage
// assumes one clock; the stage registers every level before it leaves the chip
interface sram_pins_if;
    import sram_host_pkg::*;
    logic [addr_width-1:0] addr;
    logic chip_select_n;
    logic chip_select_hi;
    logic write_n;
    logic output_en_n;
    logic upper_byte_sel_n;
    logic lower_byte_sel_n;
    logic [data_width-1:0] wdata;
    logic data_oe;
    logic [data_width-1:0] rdata;

    modport ctrl (
        output addr, chip_select_n, chip_select_hi, write_n, output_en_n,
        output upper_byte_sel_n, lower_byte_sel_n, wdata, data_oe,
        input rdata
    );
    modport pins (
        input addr, chip_select_n, chip_select_hi, write_n, output_en_n,
        input upper_byte_sel_n, lower_byte_sel_n, wdata, data_oe,
        output rdata
    );
endinterface

// ===== rtl/sram_pin_stage.sv
// registers all outgoing pin levels and double-syncs the incoming data bus
// assumes the sequencer drives the ctrl modport on the same clock
module sram_pin_stage
    import sram_host_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    sram_pins_if.pins p,
    output logic [addr_width-1:0] sram_addr,
    output logic chip_select_n,
    output logic chip_select_hi,
    output logic write_n,
    output logic output_en_n,
    output logic upper_byte_sel_n,
    output logic lower_byte_sel_n,
    output logic [data_width-1:0] sram_data_out,
    output logic sram_data_oe,
    input wire logic [data_width-1:0] sram_data_in
);
    logic [data_width-1:0] sync1_q, sync2_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sram_addr <= '0;
            chip_select_n <= 1'b1;
            chip_select_hi <= 1'b0;
            write_n <= 1'b1;
            output_en_n <= 1'b1;
            upper_byte_sel_n <= 1'b1;
            lower_byte_sel_n <= 1'b1;
            sram_data_out <= '0;
            sram_data_oe <= 1'b0;
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sram_addr <= p.addr;
            chip_select_n <= p.chip_select_n;
            chip_select_hi <= p.chip_select_hi;
            write_n <= p.write_n;
            output_en_n <= p.output_en_n;
            upper_byte_sel_n <= p.upper_byte_sel_n;
            lower_byte_sel_n <= p.lower_byte_sel_n;
            sram_data_out <= p.wdata;
            sram_data_oe <= p.data_oe;
            sync1_q <= sram_data_in;
            sync2_q <= sync1_q;
        end
    end

    assign p.rdata = sync2_q;
endmodule // sram_pin_stage

// ===== tb/sram_host_monitor.sv
// pin and answer timing checker for the sram host
// assumes a bind onto sram_host and one 200 MHz clock
module sram_host_monitor
    import sram_host_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic slow_grade,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_write,
    input wire logic [1:0] req_byte_en,
    input wire logic rsp_valid,
    input wire logic [addr_width-1:0] sram_addr,
    input wire logic chip_select_n,
    input wire logic chip_select_hi,
    input wire logic write_n,
    input wire logic output_en_n,
    input wire logic upper_byte_sel_n,
    input wire logic lower_byte_sel_n,
    input wire logic [data_width-1:0] sram_data_out,
    input wire logic sram_data_oe
);
    logic [7:0] age_q, age_d, sel_q, sel_d;
    logic [addr_width+1:0] held_q, held_d;
    // cycles that address and lane selects stood still, and select length
    always_comb begin
        held_d = {sram_addr, upper_byte_sel_n, lower_byte_sel_n};
        age_d = (held_q != held_d) ? 8'h00 : age_q + {7'h00, age_q != 8'hff};
        sel_d = chip_select_n ? 8'h00 : sel_q + 8'h01;
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            age_q <= 8'h00;
            sel_q <= 8'h00;
            held_q <= '0;
        end else begin
            age_q <= age_d;
            sel_q <= sel_d;
            held_q <= held_d;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence strobe_end;
        $rose(write_n) && !chip_select_n;
    endsequence
    sequence accept(logic w);
        req_valid && req_ready && req_write == w && req_byte_en != 2'h0 && !slow_grade;
    endsequence
    wr_in_sel_a: assert property (!write_n |-> !chip_select_n && chip_select_hi
        && !(upper_byte_sel_n && lower_byte_sel_n)) else $error("strobe outside select");
    rd_strobe_a: assert property (!output_en_n |-> write_n && !chip_select_n
        && chip_select_hi) else $error("read without select or with strobe");
    no_clash_a: assert property (!output_en_n |-> !sram_data_oe)
        else $error("host drives during read");
    oe_float_a: assert property ($rose(output_en_n) |-> !sram_data_oe [*4])
        else $error("host drives before float time");
    data_setup_a: assert property (strobe_end |-> $past(sram_data_oe, 6)
        && $past(sram_data_out, 6) == $past(sram_data_out)) else $error("data setup short");
    addr_setup_a: assert property (strobe_end |-> age_q >= (slow_grade ? 8'h0a : 8'h06))
        else $error("address or lane setup short");
    // select count at the rising sample equals the low cycles, so 11 low cycles show as 11
    cycle_len_a: assert property ($rose(chip_select_n) |-> sel_q >= (slow_grade ? 8'h0d : 8'h0a))
        else $error("cycle shorter than minimum");
    // answer registered at the 14th or 11th edge, seen one sample later
    rd_answer_a: assert property (accept(1'b0) |-> ##15 rsp_valid)
        else $error("read answer late or early");
    wr_answer_a: assert property (accept(1'b1) |-> ##12 rsp_valid)
        else $error("write answer late or early");
endmodule // sram_host_monitor

bind sram_host sram_host_monitor mon (.clock, .rst, .slow_grade, .req_valid, .req_ready,
    .req_write, .req_byte_en, .rsp_valid, .sram_addr, .chip_select_n, .chip_select_hi,
    .write_n, .output_en_n, .upper_byte_sel_n, .lower_byte_sel_n, .sram_data_out,
    .sram_data_oe);

// ===== tb/sram_dev_model.sv
// behavioural static ram seen by the host, 256 words deep
// assumes the bench resolves the data bus and sets the access time in cycles
module sram_dev_model
    import sram_host_pkg::*;
(
    input wire logic clock,
    input wire logic [addr_width-1:0] sram_addr,
    input wire logic chip_select_n,
    input wire logic chip_select_hi,
    input wire logic write_n,
    input wire logic output_en_n,
    input wire logic upper_byte_sel_n,
    input wire logic lower_byte_sel_n,
    input wire logic [data_width-1:0] dq,
    input wire logic [7:0] acc,
    output logic [data_width-1:0] dq_out,
    output logic [1:0] dq_oe
);
    logic [data_width-1:0] mem [256];
    logic [7:0] rd_cnt = 8'h00;
    logic sel, rd;
    initial for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
    assign sel = !chip_select_n && chip_select_hi && !(upper_byte_sel_n && lower_byte_sel_n);
    assign rd = sel && !output_en_n && write_n;
    assign dq_oe = rd ? {!upper_byte_sel_n, !lower_byte_sel_n} : 2'h0;
    assign dq_out = (rd_cnt >= acc) ? mem[sram_addr[7:0]] : ~mem[sram_addr[7:0]];
    always @(posedge clock) begin
        rd_cnt <= rd ? rd_cnt + 8'h01 : 8'h00;
        if (sel && !write_n && !lower_byte_sel_n) mem[sram_addr[7:0]][7:0] <= dq[7:0];
        if (sel && !write_n && !upper_byte_sel_n) mem[sram_addr[7:0]][15:8] <= dq[15:8];
    end
endmodule // sram_dev_model

// ===== tb/sram_host_tb_top.sv
// self-checking bench for the sram host against the device model
// assumes the monitor bind and the device model are compiled before it
module sram_host_tb_top import sram_host_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0, rst = 1'b1, slow_grade = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic [addr_width-1:0] req_addr = 20'h00000, sram_addr;
    logic [data_width-1:0] req_wdata = 16'h0000, rsp_rdata, sram_data_out, sram_data_in, dev_q;
    logic [data_width-1:0] last_q = 16'h0000;
    logic [1:0] req_byte_en = 2'h0, dev_oe;
    logic [7:0] acc = 8'h0a;
    logic req_ready, rsp_valid, chip_select_n, chip_select_hi, write_n, output_en_n;
    logic upper_byte_sel_n, lower_byte_sel_n, sram_data_oe;
    int error_cnt = 0, check_count = 0, lat;
    always #2.5 clock = ~clock;
    always @(posedge clock) last_q <= sram_data_in;
    // undriven lanes flip every cycle
    assign sram_data_in[7:0] = dev_oe[0] ? dev_q[7:0] :
        sram_data_oe ? sram_data_out[7:0] : ~last_q[7:0];
    assign sram_data_in[15:8] = dev_oe[1] ? dev_q[15:8] :
        sram_data_oe ? sram_data_out[15:8] : ~last_q[15:8];
    sram_host uut (.clock, .rst, .slow_grade, .req_valid, .req_ready, .req_write, .req_addr,
        .req_wdata, .req_byte_en, .rsp_valid, .rsp_rdata, .sram_addr, .chip_select_n,
        .chip_select_hi, .write_n, .output_en_n, .upper_byte_sel_n, .lower_byte_sel_n,
        .sram_data_out, .sram_data_oe, .sram_data_in);
    sram_dev_model dev (.clock, .sram_addr, .chip_select_n, .chip_select_hi, .write_n,
        .output_en_n, .upper_byte_sel_n, .lower_byte_sel_n, .dq(sram_data_in), .acc,
        .dq_out(dev_q), .dq_oe(dev_oe));
    task finish_test;
        if (error_cnt == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task wait_for(input logic want, inout int n);
        while (want === 1'b0 && n < 60) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n >= 60) begin
            error_cnt++;
            finish_test();
        end
    endtask
    task req(input logic w, input logic [19:0] a, input logic [15:0] d, input logic [1:0] be);
        int n;
        @(posedge clock);
        #1;
        {req_valid, req_write, req_addr, req_wdata, req_byte_en} = {1'b1, w, a, d, be};
        n = 0;
        while (req_ready !== 1'b1 && n < 60) begin
            @(posedge clock);
            #1;
            n++;
        end
        @(posedge clock);
        #1;
        req_valid = 1'b0;
        lat = 0;
        while (rsp_valid !== 1'b1 && lat < 60) begin
            @(posedge clock);
            #1;
            lat++;
        end
        if (n >= 60 || lat >= 60) begin
            error_cnt++;
            finish_test();
        end
    endtask
    task do_reset;
        rst = 1'b1;
        repeat (16) @(posedge clock);
        #1;
        rst = 1'b0;
    endtask
    task t_word;
        int n;
        req(1'b1, 20'h00012, 16'ha5c3, 2'h3);
        check("write answer", lat, 11);
        n = 0;
        while (req_ready !== 1'b1 && n < 60) begin
            @(posedge clock);
            #1;
            n++;
        end
        check("float gap", n, 4);
        req(1'b0, 20'h00012, 16'h0000, 2'h3);
        check("read answer", lat, 14);
        check("read word", rsp_rdata, 16'ha5c3);
    endtask
    task t_lanes;
        req(1'b1, 20'h00005, 16'h1111, 2'h3);
        req(1'b1, 20'h00005, 16'h00ab, 2'h1);
        req(1'b1, 20'h00005, 16'hcd00, 2'h2);
        req(1'b0, 20'h00005, 16'h0000, 2'h3);
        check("merged lanes", rsp_rdata, 16'hcdab);
        req(1'b0, 20'h00005, 16'h0000, 2'h1);
        check("low lane only", rsp_rdata, 16'h00ab);
        req(1'b0, 20'h00005, 16'h0000, 2'h2);
        check("high lane only", rsp_rdata, 16'hcd00);
    endtask
    task t_none;
        req(1'b1, 20'h00040, 16'hffff, 2'h0);
        check("empty answer", lat, 0);
        check("no select", chip_select_n, 1'b1);
        req(1'b0, 20'h00040, 16'h0000, 2'h3);
        check("nothing written", rsp_rdata, 16'h0000);
    endtask
    task t_slow;
        slow_grade = 1'b1;
        acc = 8'h0d;
        req(1'b1, 20'h000fe, 16'h5a96, 2'h3);
        check("slow write answer", lat, 14);
        req(1'b0, 20'h000fe, 16'h0000, 2'h3);
        check("slow read answer", lat, 17);
        check("slow read word", rsp_rdata, 16'h5a96);
        @(posedge clock);
        #1;
        slow_grade = 1'b0;
        acc = 8'h0a;
    endtask
    task t_reset;
        // let the previous float gap end so the read is taken
        repeat (6) @(posedge clock);
        @(posedge clock);
        #1;
        {req_valid, req_write, req_addr, req_byte_en} = {1'b1, 1'b0, 20'h00012, 2'h3};
        @(posedge clock);
        #1;
        req_valid = 1'b0;
        repeat (5) @(posedge clock);
        #1;
        rst = 1'b1;
        #1;
        check("reset deselect", {chip_select_n, chip_select_hi, output_en_n}, 3'h5);
        check("reset bus", {write_n, sram_data_oe, req_ready}, 3'h5);
        do_reset();
    endtask
    initial begin
        do_reset();
        t_word();
        t_lanes();
        t_none();
        t_slow();
        t_reset();
        t_word();
        finish_test();
    end
endmodule // sram_host_tb_top
